// file: dhs_pkg.sv
package dhs_pkg;
    // ------------------------------------------------------------
    // Serial mode codes in the two low bits of the control register
    // ------------------------------------------------------------
    localparam logic [1:0] DHS_MODE_START = 2'h0;
    localparam logic [1:0] DHS_MODE_NINE = 2'h1;
    localparam logic [1:0] DHS_MODE_FOUR = 2'h2;
    // Arbitrary value for the fixed upper code bits of the start byte
    localparam logic [4:0] DHS_ID_UPPER = 5'h15;
    // ------------------------------------------------------------
    // Register map of the controller (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DHS_REG_CTRL = 8'h00;
    localparam logic [7:0] DHS_REG_CMD = 8'h04;
    localparam logic [7:0] DHS_REG_STATUS = 8'h08;
    localparam logic [7:0] DHS_REG_RDATA = 8'h0C;
    localparam logic [7:0] DHS_REG_DIV = 8'h10;
    localparam int DHS_CTRL_MODE_LSB = 0;
    localparam int DHS_CTRL_ID_BIT = 2;
    localparam int DHS_CMD_KIND_BIT = 8;
    localparam int DHS_CMD_READ_BIT = 9;
    localparam int DHS_CMD_HOLD_BIT = 10;
    localparam int DHS_CMD_DUMMY_LSB = 12;
    localparam logic [7:0] DHS_DIV_RESET = 8'h08;
    localparam logic [2:0] DHS_DUMMY_FRAME = 3'h5;
    localparam logic [2:0] DHS_DUMMY_STATUS = 3'h1;
    typedef enum logic [2:0] {
        DHS_IDLE = 3'b000,
        DHS_SELECT = 3'b001,
        DHS_SHIFT = 3'b010,
        DHS_NEXT = 3'b011,
        DHS_RELEASE = 3'b100
    } dhs_state_type;
endpackage

// file: dhs_clkdiv.sv
`timescale 1ns/10ps
module dhs_clkdiv (
    input wire logic clk, // System clock
    input wire logic resetn, // Synchronous reset, low
    input wire logic run, // Count while high
    input wire logic [7:0] half_period, // Cycles per half serial period
    output logic tick // One-cycle pulse at each half period
);
    typedef struct packed {
        logic [7:0] count;
        logic tick;
    } dhs_div_type;
    dhs_div_type r, next_r;
    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (!run) begin
            next_r.count = 8'h00;
        end else if (r.count + 8'h01 >= half_period) begin
            next_r.count = 8'h00;
            next_r.tick = 1'b1;
        end else begin
            next_r.count = r.count + 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign tick = r.tick;
endmodule // dhs_clkdiv

// file: dhs_host.sv
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module dhs_host
    import dhs_pkg::*;
(
    input wire logic clk, // System clock 125 MHz
    input wire logic resetn, // Synchronous reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic chip_select_n, // Device chip select
    output logic write_strobe_or_serial_clock, // Serial clock out
    output logic data_command_select_pin, // Four-wire data/command pin
    output logic serial_out, // Host data to device
    output logic serial_out_en, // Drive enable of data line
    input wire logic serial_in_line // Data line level from device
);
    import dhs_pkg::*;
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        dhs_state_type state;
        logic [1:0] mode;
        logic id_bit;
        logic [7:0] half_period;
        logic [7:0] byte_out;
        logic kind;
        logic read;
        logic hold;
        logic [2:0] dummies;
        logic pending;
        logic busy;
        logic rvalid;
        logic [7:0] rdata;
        logic [8:0] shreg;
        logic [3:0] bits;
        logic [3:0] nbits;
        logic start_phase;
        logic sclk;
        logic csn;
        logic dc;
        logic sdo;
        logic sdo_en;
        logic [7:0] rx;
        logic [2:0] skip;
        logic [31:0] prdata;
        logic [1:0] din_sync;
    } dhs_host_type;
    dhs_host_type r, next_r;
    logic tick;
    logic din;
    logic access;
    logic [3:0] word_bits;
    logic [8:0] word_value;
    logic bus_err;

    dhs_clkdiv u_div (
        .clk(clk),
        .resetn(resetn),
        .run(r.state != DHS_IDLE),
        .half_period(r.half_period),
        .tick(tick)
    );

    assign din = r.din_sync[1];
    assign access = psel && penable;

    // ------------------------------------------------------------
    // Word framing for the current mode
    // ------------------------------------------------------------
    always_comb begin
        word_bits = 4'h8;
        word_value = {1'b0, r.byte_out};
        if (r.mode == DHS_MODE_NINE) begin
            word_bits = 4'h9;
            word_value = {r.kind, r.byte_out};
        end
    end

    always_comb begin
        next_r = r;
        next_r.din_sync = {r.din_sync[0], serial_in_line};
        bus_err = 1'b0;
        // --------------------------------------------------------
        // Register slave
        // --------------------------------------------------------
        // Read data is captured in the setup cycle so it already stands
        // at the edge where the access completes
        if (psel && !penable) begin
            if (paddr == DHS_REG_CTRL) begin
                next_r.prdata = {29'h0, r.id_bit, r.mode};
            end else if (paddr == DHS_REG_CMD) begin
                next_r.prdata = {17'h0, r.dummies, 1'b0, r.hold, r.read, r.kind, r.byte_out};
            end else if (paddr == DHS_REG_STATUS) begin
                next_r.prdata = {29'h0, r.rvalid, r.pending, r.busy};
            end else if (paddr == DHS_REG_RDATA) begin
                next_r.prdata = {24'h0, r.rdata};
            end else if (paddr == DHS_REG_DIV) begin
                next_r.prdata = {24'h0, r.half_period};
            end else begin
                next_r.prdata = 32'h0;
            end
        end
        if (access) begin
            if (paddr == DHS_REG_CTRL) begin
                if (pwrite && !r.busy) begin
                    next_r.mode = pwdata[DHS_CTRL_MODE_LSB +: 2];
                    next_r.id_bit = pwdata[DHS_CTRL_ID_BIT];
                end
            end else if (paddr == DHS_REG_CMD) begin
                if (pwrite && !r.pending) begin
                    next_r.byte_out = pwdata[7:0];
                    next_r.kind = pwdata[DHS_CMD_KIND_BIT];
                    next_r.read = pwdata[DHS_CMD_READ_BIT];
                    next_r.hold = pwdata[DHS_CMD_HOLD_BIT];
                    next_r.dummies = pwdata[DHS_CMD_DUMMY_LSB +: 3];
                    next_r.pending = 1'b1;
                end else if (pwrite) begin
                    bus_err = 1'b1;
                end
            end else if (paddr == DHS_REG_RDATA) begin
                if (!pwrite) begin
                    next_r.rvalid = 1'b0;
                end
            end else if (paddr == DHS_REG_DIV) begin
                if (pwrite && pwdata[7:0] != 8'h00) begin
                    next_r.half_period = pwdata[7:0];
                end
            end else if (paddr != DHS_REG_STATUS) begin
                bus_err = 1'b1;
            end
        end
        // --------------------------------------------------------
        // Serial engine
        // --------------------------------------------------------
        case (r.state)
            DHS_IDLE: begin
                next_r.sclk = 1'b0;
                next_r.csn = 1'b1;
                next_r.sdo_en = 1'b0;
                if (r.pending) begin
                    next_r.busy = 1'b1;
                    next_r.csn = 1'b0;
                    next_r.state = DHS_SELECT;
                    next_r.start_phase = (r.mode == DHS_MODE_START) && r.csn;
                end
            end
            DHS_SELECT: begin
                if (tick) begin
                    next_r.sdo_en = 1'b1;
                    next_r.dc = r.kind;
                    next_r.skip = r.read ? r.dummies : 3'h0;
                    if (r.start_phase) begin
                        next_r.shreg = {DHS_ID_UPPER, r.id_bit, r.kind, r.read, 1'b0};
                        next_r.nbits = 4'h8;
                    end else begin
                        // Nine-bit reads run as word writes; software enables reads first
                        next_r.shreg = word_value << (4'h9 - word_bits);
                        next_r.nbits = word_bits;
                        if (r.read && r.mode == DHS_MODE_START) begin
                            next_r.sdo_en = 1'b0;
                        end
                    end
                    next_r.sdo = next_r.shreg[8];
                    next_r.bits = 4'h0;
                    next_r.state = DHS_SHIFT;
                end
            end
            DHS_SHIFT: begin
                if (tick && !r.sclk) begin
                    next_r.sclk = 1'b1;
                    next_r.rx = {r.rx[6:0], din};
                    next_r.bits = r.bits + 4'h1;
                end else if (tick) begin
                    next_r.sclk = 1'b0;
                    if (r.bits == r.nbits) begin
                        next_r.state = DHS_NEXT;
                    end else begin
                        next_r.shreg = {r.shreg[7:0], 1'b0};
                        next_r.sdo = r.shreg[7];
                    end
                end
            end
            DHS_NEXT: begin
                next_r.sclk = 1'b0;
                if (r.start_phase) begin
                    next_r.start_phase = 1'b0;
                    // Let go of the line one clock after the device starts answering
                    if (r.read) begin
                        next_r.sdo_en = 1'b0;
                    end
                    next_r.state = DHS_SELECT;
                end else begin
                    if (r.read && r.skip != 3'h0) begin
                        next_r.skip = r.skip - 3'h1;
                        next_r.nbits = 4'h8;
                        next_r.bits = 4'h0;
                        next_r.sdo_en = 1'b0;
                        next_r.state = DHS_SHIFT;
                    end else begin
                        if (r.read) begin
                            next_r.rdata = r.rx;
                            next_r.rvalid = 1'b1;
                        end
                        next_r.pending = 1'b0;
                        // A held frame keeps select low so multi-byte pixels share it;
                        // busy low in release marks the frame as held open
                        next_r.busy = !r.hold;
                        next_r.state = DHS_RELEASE;
                    end
                end
            end
            DHS_RELEASE: begin
                if (!r.busy) begin
                    if (r.pending) begin
                        next_r.busy = 1'b1;
                        next_r.start_phase = 1'b0;
                        next_r.state = DHS_SELECT;
                    end
                end else if (tick) begin
                    next_r.csn = 1'b1;
                    next_r.sdo_en = 1'b0;
                    next_r.busy = 1'b0;
                    next_r.state = DHS_IDLE;
                end
            end
            default: begin
                next_r.state = DHS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
            r.state <= DHS_IDLE;
            r.csn <= 1'b1;
            r.half_period <= DHS_DIV_RESET;
            r.mode <= DHS_MODE_FOUR;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = 1'b1;
    assign pslverr = bus_err;
    assign chip_select_n = r.csn;
    assign write_strobe_or_serial_clock = r.sclk;
    assign data_command_select_pin = r.dc;
    assign serial_out = r.sdo;
    assign serial_out_en = r.sdo_en;
endmodule // dhs_host

// file: dhs_host_assertions.sv
`timescale 1ns/10ps
module dhs_host_checker
    import dhs_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic resetn, // Reset
    input wire logic psel, // APB
    input wire logic penable, // APB
    input wire logic pwrite, // APB
    input wire logic [7:0] paddr, // APB
    input wire logic [31:0] pwdata, // APB
    input wire logic [31:0] prdata, // APB
    input wire logic pready, // APB
    input wire logic pslverr, // APB
    input wire logic chip_select_n, // Select
    input wire logic write_strobe_or_serial_clock, // Serial clock
    input wire logic data_command_select_pin, // Kind pin
    input wire logic serial_out, // Data out
    input wire logic serial_out_en, // Drive
    input wire logic serial_in_line // Data in
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic sck;
    logic sck_q;
    int rises;
    assign sck = write_strobe_or_serial_clock;
    // Rising clock edges seen in the current frame
    always_ff @(posedge clk) begin
        sck_q <= sck;
        if (!resetn || chip_select_n) begin
            rises <= 0;
        end else if (sck && !sck_q) begin
            rises <= rises + 1;
        end
    end
    quiet_deselect_a: assert property (chip_select_n |-> !sck)
        else $error("serial clock high while deselected");
    stable_high_a: assert property (sck && $past(sck) |-> $stable(serial_out))
        else $error("data changed while clock high");
    high_time_a: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
        else $error("clock high time not one half period");
    rise_selected_a: assert property ($rose(sck) |-> !chip_select_n && $past(!chip_select_n))
        else $error("clock rose outside a frame");
    select_start_a: assert property (psel && penable && pwrite && paddr == DHS_REG_CMD
        && !pslverr && chip_select_n |-> ##[1:3] !chip_select_n)
        else $error("command did not open a frame");
    apb_ready_a: assert property (psel && penable |-> pready)
        else $error("access without ready");
    unmapped_err_a: assert property (psel && penable && paddr == 8'h14 |-> pslverr)
        else $error("unmapped access without error");
    whole_words_a: assert property ($rose(chip_select_n)
        |-> rises > 0 && (rises % 8 == 0 || rises % 9 == 0))
        else $error("frame ended inside a word");
endmodule // dhs_host_checker

bind dhs_host dhs_host_checker chk_u (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_n(chip_select_n), .write_strobe_or_serial_clock(write_strobe_or_serial_clock),
    .data_command_select_pin(data_command_select_pin), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .serial_in_line(serial_in_line)
);

// file: dhs_device_model.sv
`timescale 1ns/10ps
module dhs_device_model #(
    parameter logic [4:0] ID_UPPER = 5'h15 // Arbitrary value
) (
    input wire logic chip_select_n, // Select
    input wire logic serial_clock, // Serial clock
    input wire logic dc_pin, // Kind pin
    input wire logic data_in, // Line level
    input wire logic [2:0] mode_pins, // Mode pins
    input wire logic [7:0] read_byte, // Read answer
    output logic data_out, // Data out
    output logic data_out_en // Drive
);
    logic [8:0] rx_q[$];
    logic [8:0] shreg;
    logic [7:0] tx_byte;
    logic started, accept, reading, sel_bit, kind;
    int nbits;
    int nbytes;
    initial data_out_en = 1'b0;
    initial data_out = 1'b1;
    // Any select change restarts framing, so a partial word is lost
    always @(chip_select_n) begin
        nbits = 0;
        nbytes = 0;
        started = 1'b0;
        accept = mode_pins[2];
        reading = 1'b0;
        data_out_en = 1'b0;
    end
    always @(posedge serial_clock) begin
        if (!chip_select_n && accept) begin
            shreg = {shreg[7:0], data_in};
            nbits++;
            if (nbits == ((mode_pins == 3'h6) ? 9 : 8)) begin
                nbits = 0;
                kind = mode_pins[1] ? (mode_pins[0] ? dc_pin : shreg[8]) : sel_bit;
                if (!mode_pins[1] && !started) begin
                    started = 1'b1;
                    accept = (shreg[7:2] == {ID_UPPER, mode_pins[0]});
                    sel_bit = shreg[1];
                    reading = shreg[0];
                end else if (reading) begin
                    nbytes++;
                end else begin
                    rx_q.push_back({kind, shreg[7:0]});
                end
            end
        end
    end
    // Dummies are inverted so a host that keeps them is caught
    always @(negedge serial_clock) begin
        if (!chip_select_n && reading) begin
            tx_byte = (nbytes < (sel_bit ? 5 : 1)) ? ~read_byte : read_byte;
            data_out = tx_byte[7 - nbits];
            data_out_en = 1'b1;
        end
    end
endmodule // dhs_device_model

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
    import dhs_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, csn, sclk, dc, sout, sout_en, dev_out, dev_en, err;
    logic [2:0] pins = 3'h7;
    logic [7:0] rbyte = 8'h00;
    int fail_count = 0;
    int checks = 0;
    // Data line has a pull-up when nobody drives it
    wire line = sout_en ? sout : (dev_en ? dev_out : 1'b1);
    always #4 clk = ~clk;
    dhs_host dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chip_select_n(csn), .write_strobe_or_serial_clock(sclk),
        .data_command_select_pin(dc), .serial_out(sout), .serial_out_en(sout_en),
        .serial_in_line(line));
    dhs_device_model #(.ID_UPPER(DHS_ID_UPPER)) dev_u (.chip_select_n(csn),
        .serial_clock(sclk), .dc_pin(dc), .data_in(line), .mode_pins(pins),
        .read_byte(rbyte), .data_out(dev_out), .data_out_en(dev_en));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input logic [31:0] cmd);
        apb(1'b1, DHS_REG_CMD, cmd);
        repeat (400) begin
            apb(1'b0, DHS_REG_STATUS, 32'h0);
            if (rd[1:0] === 2'b00) break;
        end
    endtask
    task automatic t_regs;
        check("csn", csn, 1'b1);
        check("sclk", sclk, 1'b0);
        check("oe", sout_en, 1'b0);
        apb(1'b1, DHS_REG_DIV, 32'h0);
        apb(1'b0, DHS_REG_DIV, 32'h0);
        check("div", rd, {24'h0, DHS_DIV_RESET});
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped", err, 1'b1);
    endtask
    task automatic t_writes;
        logic [1:0] code[3] = '{DHS_MODE_FOUR, DHS_MODE_NINE, DHS_MODE_START};
        logic [2:0] pin[3] = '{3'h7, 3'h6, 3'h4};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            pins <= pin[i];
            apb(1'b1, DHS_REG_CTRL, {29'h0, pin[i][0], code[i]});
            send(32'h0000_043C);
            check("held", csn, 1'b0);
            send(32'h0000_01A5);
            check("count", dev_u.rx_q.size(), 2);
            check("first", dev_u.rx_q.pop_front(), 9'h03C);
            check("second", dev_u.rx_q.pop_front(), {i != 2, 8'hA5});
        end
    endtask
    task automatic t_mismatch;
        apb(1'b1, DHS_REG_CTRL, 32'h0000_0004);
        send(32'h0000_0177);
        check("ignored", dev_u.rx_q.size(), 0);
    endtask
    task automatic t_reads;
        apb(1'b1, DHS_REG_CTRL, 32'h0);
        for (int j = 0; j < 2; j++) begin
            rbyte <= j ? 8'h5A : 8'hC3;
            send(j ? 32'h0000_5300 : 32'h0000_1200);
            apb(1'b0, DHS_REG_STATUS, 32'h0);
            check("rvalid", rd[2], 1'b1);
            apb(1'b0, DHS_REG_RDATA, 32'h0);
            check("rdata", rd[7:0], j ? 8'h5A : 8'hC3);
            apb(1'b0, DHS_REG_STATUS, 32'h0);
            check("rclear", rd[2], 1'b0);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_regs;
        t_writes;
        t_mismatch;
        t_reads;
        end_of_test;
    end
    // Whole run needs well under ten thousand cycles
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        end_of_test;
    end
endmodule // testbench
